// *** hdl/hmcs_pkg.sv ***
/*
  package for the host mode strap and clock select block: mode codes,
  strap pin layout, clock source codes, counter widths and reset values.
  assumes a single core clock domain and a synchronous active high reset.
*/
package hmcs_pkg;

  // ------------------------------------------------------------------
  // host interface modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HMCS_MODE_PAR_A = 2'b00,
    HMCS_MODE_PAR_B = 2'b01,
    HMCS_MODE_I2C   = 2'b10,
    HMCS_MODE_SPI   = 2'b11
  } hmcs_mode_t;

  // ------------------------------------------------------------------
  // strap pins, as sampled at reset release
  // ------------------------------------------------------------------
  typedef struct packed {
    logic rd_strap;
    logic wr_strap;
    logic psel_strap;
  } hmcs_strap_t;

  // one-hot interface enables
  typedef struct packed {
    logic par_a_en;
    logic par_b_en;
    logic i2c_en;
    logic spi_en;
  } hmcs_if_en_t;

  // ------------------------------------------------------------------
  // pll reference sources
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HMCS_REF_EXT  = 2'b00,
    HMCS_REF_BCK1 = 2'b01,
    HMCS_REF_BCK2 = 2'b10
  } hmcs_ref_t;

  localparam int         HMCS_GPIO_W     = 12;
  localparam int         HMCS_STC_W      = 33;
  localparam int         HMCS_DIV_W      = 8;
  localparam hmcs_mode_t HMCS_MODE_RST   = HMCS_MODE_SPI;
  localparam hmcs_ref_t  HMCS_REF_RST    = HMCS_REF_EXT;
  localparam logic [7:0] HMCS_BCK_DIV_RST = 8'h04;
  localparam logic [7:0] HMCS_FRM_DIV_RST = 8'h40;

endpackage

// *** hdl/hmcs_clk_div.sv ***
/*
  programmable divider producing one-cycle ticks and a square level.
  assumes the enclosing block supplies the clock enable and the reset.
*/
`timescale 1ns/100ps
`default_nettype none

module hmcs_clk_div #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] half_period,
  // outputs
  output var  logic         tick,
  output var  logic         level
);

  logic [W-1:0] cnt_reg;
  logic         level_reg;
  wire          wrap = run && (cnt_reg >= half_period - W'(1));

  assign tick  = wrap && clk_en && !level_reg;
  assign level = level_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg   <= wrap ? '0 : cnt_reg + W'(1);
      if (wrap)
        level_reg <= !level_reg;
    end
  end

endmodule

`default_nettype wire

// *** hdl/hmcs_top.sv ***
/*
  start-up strap capture, host interface selection, mode dependent pin
  control and clock manager (bypass, reference mux, time counter).
  assumes all inputs synchronous to core_clk; pin level resolution and
  pull-ups live outside; the pll itself is an analog macro outside.
*/
// Behaviour
// - at reset release sample rd, wr, psel straps; 11 parallel, 01 i2c, 10 spi
// - after strap capture exactly one host interface enabled, the one the straps chose; none before
// - interrupt request is open drain: pull low or release, never high
// - in i2c mode the bidirectional data pin is open drain only
// - outside parallel modes all twelve general pins are undriven inputs
// - bypass select high routes external clock straight to the core clock
// - bypass select low clocks the core from the pll output
// - pll reference from three sources, chosen by dsp control, not pins
// - pll output yields internal clocks and master bit and frame timing
// - a 33-bit system time counter kept by the clock manager
`timescale 1ns/100ps
`default_nettype none

module hmcs_top
  import hmcs_pkg::*;
#(
  parameter int GPIO_W = hmcs_pkg::HMCS_GPIO_W,
  parameter int STC_W  = hmcs_pkg::HMCS_STC_W
) (
  // clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // strap pins
  input  wire hmcs_pkg::hmcs_strap_t strap_pins,
  // host mode result
  output var  hmcs_pkg::hmcs_mode_t  host_mode,
  output var  hmcs_pkg::hmcs_if_en_t host_if_en,
  // interrupt request pin, open drain
  input  wire logic                  irq_assert,
  output var  logic                  host_interrupt_request_o,
  output var  logic                  host_interrupt_request_oe,
  // serial bidirectional data pin
  input  wire logic                  sdata_drive_req,
  input  wire logic                  sdata_out_val,
  output var  logic                  serial_bidir_data_o,
  output var  logic                  serial_bidir_data_oe,
  // general purpose pins
  input  wire logic [GPIO_W-1:0]     gpio_out_val,
  input  wire logic [GPIO_W-1:0]     gpio_drive_req,
  output var  logic [GPIO_W-1:0]     gpio_o,
  output var  logic [GPIO_W-1:0]     gpio_oe,
  // clock sources and bypass strap
  input  wire logic                  pll_bypass_select,
  input  wire logic                  external_clock_input,
  input  wire logic                  serial_bit_clock_one,
  input  wire logic                  serial_bit_clock_two,
  input  wire logic                  pll_clock_out,
  // dsp side clock manager control
  input  wire hmcs_pkg::hmcs_ref_t   ref_sel,
  input  wire logic                  ref_sel_we,
  input  wire logic [7:0]            bck_half_div,
  input  wire logic [7:0]            frm_half_div,
  input  wire logic                  master_timing_en,
  input  wire logic                  stc_load,
  input  wire logic [STC_W-1:0]      stc_load_val,
  // clock manager outputs
  output var  logic                  pll_ref_clock,
  output var  logic                  dsp_core_clock,
  output var  hmcs_pkg::hmcs_ref_t   ref_sel_state,
  output var  logic                  master_bit_clock,
  output var  logic                  master_frame_clock,
  output var  logic [STC_W-1:0]      system_time_counter
);

  import hmcs_pkg::*;

  // ------------------------------------------------------------------
  // strap decode and capture
  // ------------------------------------------------------------------
  function automatic hmcs_mode_t decode_strap(input hmcs_strap_t s);
    hmcs_mode_t m;
    m = HMCS_MODE_RST;
    if (s.rd_strap && s.wr_strap)
      m = s.psel_strap ? HMCS_MODE_PAR_A : HMCS_MODE_PAR_B;
    else if (!s.rd_strap && s.wr_strap)
      m = HMCS_MODE_I2C;
    else if (s.rd_strap && !s.wr_strap)
      m = HMCS_MODE_SPI;
    return m;
  endfunction

  logic       in_rst_reg;
  hmcs_mode_t mode_reg;
  wire        rst_release = in_rst_reg && !sys_rst;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_rst_reg <= 1'b1;
      mode_reg   <= HMCS_MODE_RST;
    end else if (clk_en && rst_release) begin
      in_rst_reg <= 1'b0;
      mode_reg   <= decode_strap(strap_pins);
    end
  end

  // ------------------------------------------------------------------
  // interface enables and pin control
  // ------------------------------------------------------------------
  wire par_mode = (mode_reg == HMCS_MODE_PAR_A) ||
                  (mode_reg == HMCS_MODE_PAR_B);
  wire running  = !in_rst_reg;

  assign host_mode = mode_reg;
  // one driver for the whole struct, one field per mode
  assign host_if_en = '{
    par_a_en: running && (mode_reg == HMCS_MODE_PAR_A),
    par_b_en: running && (mode_reg == HMCS_MODE_PAR_B),
    i2c_en:   running && (mode_reg == HMCS_MODE_I2C),
    spi_en:   running && (mode_reg == HMCS_MODE_SPI)
  };

  logic irq_oe_reg;
  logic sd_o_reg;
  logic sd_oe_reg;
  logic [GPIO_W-1:0] gpio_o_reg;
  logic [GPIO_W-1:0] gpio_oe_reg;

  wire i2c_mode = host_if_en.i2c_en;
  wire spi_mode = host_if_en.spi_en;
  // i2c: drive only a low, release for a one
  wire sd_oe_next = (i2c_mode && sdata_drive_req && !sdata_out_val) ||
                    (spi_mode && sdata_drive_req);
  wire sd_o_next  = i2c_mode ? 1'b0 : sdata_out_val;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_oe_reg  <= 1'b0;
      sd_o_reg    <= 1'b0;
      sd_oe_reg   <= 1'b0;
      gpio_o_reg  <= '0;
      gpio_oe_reg <= '0;
    end else if (clk_en) begin
      irq_oe_reg  <= running && irq_assert;
      sd_o_reg    <= sd_o_next;
      sd_oe_reg   <= sd_oe_next;
      gpio_o_reg  <= gpio_out_val;
      gpio_oe_reg <= (running && par_mode) ? gpio_drive_req : '0;
    end
  end

  assign host_interrupt_request_o  = 1'b0;
  assign host_interrupt_request_oe = irq_oe_reg;
  assign serial_bidir_data_o       = sd_o_reg;
  assign serial_bidir_data_oe      = sd_oe_reg;
  assign gpio_o                    = gpio_o_reg;
  assign gpio_oe                   = gpio_oe_reg;

  // ------------------------------------------------------------------
  // clock manager: reference mux and core clock bypass
  // ------------------------------------------------------------------
  hmcs_ref_t ref_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ref_reg <= HMCS_REF_RST;
    else if (clk_en && ref_sel_we && ref_sel != 2'h3)
      ref_reg <= ref_sel;
  end

  assign ref_sel_state = ref_reg;
  assign pll_ref_clock =
    (ref_reg == HMCS_REF_BCK1) ? serial_bit_clock_one :
    (ref_reg == HMCS_REF_BCK2) ? serial_bit_clock_two :
                                 external_clock_input;
  // bypass high: external clock straight through, else pll output
  assign dsp_core_clock = pll_bypass_select ? external_clock_input
                                            : pll_clock_out;

  // ------------------------------------------------------------------
  // master bit timing counted in core clock cycles, frame timing in bit clock periods
  // ------------------------------------------------------------------
  logic bck_tick;
  logic bck_level;
  logic frm_level;

  hmcs_clk_div #(.W(HMCS_DIV_W)) u_bck_div (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .run         (master_timing_en && running),
    .half_period (bck_half_div),
    .tick        (bck_tick),
    .level       (bck_level)
  );

  hmcs_clk_div #(.W(HMCS_DIV_W)) u_frm_div (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en && bck_tick),
    .run         (master_timing_en && running),
    .half_period (frm_half_div),
    .tick        (),
    .level       (frm_level)
  );

  assign master_bit_clock   = bck_level;
  assign master_frame_clock = frm_level;

  // ------------------------------------------------------------------
  // system time counter
  // ------------------------------------------------------------------
  logic [STC_W-1:0] stc_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      stc_reg <= '0;
    else if (clk_en) begin
      if (stc_load)
        stc_reg <= stc_load_val;
      else
        stc_reg <= stc_reg + STC_W'(1);
    end
  end

  assign system_time_counter = stc_reg;

endmodule

`default_nettype wire

// *** dv/hmcs_chk.sv ***
/*
  port checker for hmcs_top: strap capture, interface enables, pin
  drive rules, core clock mux and time counter.
  assumes one core clock and a synchronous active high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module hmcs_chk
  import hmcs_pkg::*;
#(
  parameter int GPIO_W = 12,
  parameter int STC_W  = 33
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  // straps and mode
  input wire hmcs_pkg::hmcs_strap_t strap_pins,
  input wire hmcs_pkg::hmcs_mode_t  host_mode,
  input wire hmcs_pkg::hmcs_if_en_t host_if_en,
  // pins
  input wire logic                  irq_assert,
  input wire logic                  host_interrupt_request_o,
  input wire logic                  host_interrupt_request_oe,
  input wire logic                  serial_bidir_data_o,
  input wire logic                  serial_bidir_data_oe,
  input wire logic [GPIO_W-1:0]     gpio_oe,
  // clocks and counter
  input wire logic                  pll_bypass_select,
  input wire logic                  external_clock_input,
  input wire logic                  pll_clock_out,
  input wire logic                  dsp_core_clock,
  input wire logic                  stc_load,
  input wire logic [STC_W-1:0]      system_time_counter
);
  logic [1:0] cap_mode;
  logic       par_on;
  logic       run_on;

  // style select high picks the first parallel style
  assign cap_mode = (strap_pins.rd_strap & strap_pins.wr_strap) ?
                    {1'b0, ~strap_pins.psel_strap} :
                    (strap_pins.wr_strap ? 2'h2 : 2'h3);
  assign par_on = host_if_en.par_a_en | host_if_en.par_b_en;
  assign run_on = host_if_en != 4'h0;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  strap_capture_a: assert property (clk_en && $fell(sys_rst) |=>
    host_mode == $past(cap_mode)) else $error("mode not from straps");
  one_iface_a: assert property (host_if_en != 0 |->
    host_if_en == (4'h8 >> host_mode)) else $error("enable not one-hot");
  mode_hold_a: assert property (host_if_en != 0 |=> $stable(host_mode))
    else $error("mode changed without reset");
  irq_low_a: assert property (host_interrupt_request_o == 1'b0)
    else $error("irq driven high");
  irq_follow_a: assert property (clk_en |=>
    host_interrupt_request_oe == ($past(irq_assert) && $past(run_on)))
    else $error("irq lag");
  i2c_drain_a: assert property (host_if_en.i2c_en && serial_bidir_data_oe
    |-> !serial_bidir_data_o) else $error("i2c data driven high");
  gpio_float_a: assert property (!par_on |-> gpio_oe == '0)
    else $error("gpio driven in serial mode");
  bypass_clock_a: assert property (pll_bypass_select |->
    dsp_core_clock == external_clock_input) else $error("bypass mux");
  pll_clock_a: assert property (!pll_bypass_select |->
    dsp_core_clock == pll_clock_out) else $error("pll mux");
  stc_count_a: assert property (clk_en && !stc_load |=> system_time_counter
    == STC_W'($past(system_time_counter) + 1)) else $error("stc count");
  iface_on_a: assert property (clk_en && $fell(sys_rst) |=> run_on)
    else $error("no interface enabled after capture");
  enable_freeze_a: assert property (!clk_en |=>
    $stable(system_time_counter) && $stable(gpio_oe) &&
    $stable(host_interrupt_request_oe)) else $error("state moved on hold");
endmodule

bind hmcs_top hmcs_chk #(
  .GPIO_W (GPIO_W),
  .STC_W  (STC_W)
) u_hmcs_chk (
  .core_clk                  (core_clk),
  .sys_rst                   (sys_rst),
  .clk_en                    (clk_en),
  .strap_pins                (strap_pins),
  .host_mode                 (host_mode),
  .host_if_en                (host_if_en),
  .irq_assert                (irq_assert),
  .host_interrupt_request_o  (host_interrupt_request_o),
  .host_interrupt_request_oe (host_interrupt_request_oe),
  .serial_bidir_data_o       (serial_bidir_data_o),
  .serial_bidir_data_oe      (serial_bidir_data_oe),
  .gpio_oe                   (gpio_oe),
  .pll_bypass_select         (pll_bypass_select),
  .external_clock_input      (external_clock_input),
  .pll_clock_out             (pll_clock_out),
  .dsp_core_clock            (dsp_core_clock),
  .stc_load                  (stc_load),
  .system_time_counter       (system_time_counter)
);

`default_nettype wire

// *** dv/hmcs_host_model.sv ***
/*
  host side pin model: pull-ups on the open drain lines.
  assumes the host talks only through the chosen port, never pins.
*/
`timescale 1ns/100ps
`default_nettype none

module hmcs_host_model (
  // device pin drive
  input  wire logic irq_oe,
  input  wire logic sd_o,
  input  wire logic sd_oe,
  // resolved levels
  output var  logic irq_pin,
  output var  logic sd_pin
);
  // pull-ups raise released lines; host drives neither
  assign irq_pin = irq_oe ? 1'b0 : 1'b1;
  assign sd_pin  = sd_oe ? sd_o : 1'b1;
endmodule

`default_nettype wire

// *** dv/tb.sv ***
/*
  testbench for hmcs_top: strap modes, pin drive, clock manager.
  assumes hmcs_chk is bound and inputs change at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import hmcs_pkg::*;
  logic core_clk = 0, sys_rst = 1, clk_en = 1;
  hmcs_strap_t strap_pins = '0;
  logic irq_assert = 0, sdata_drive_req = 0, sdata_out_val = 0;
  logic [11:0] gpio_out_val = 12'hA5A, gpio_drive_req = '0;
  logic pll_bypass_select = 0, external_clock_input = 0, pll_clock_out = 0;
  logic serial_bit_clock_one = 0, serial_bit_clock_two = 0;
  hmcs_ref_t ref_sel = HMCS_REF_EXT;
  logic ref_sel_we = 0, master_timing_en = 0, stc_load = 0;
  logic [7:0] bck_half_div = 8'h02, frm_half_div = 8'h02;
  logic [32:0] stc_load_val = '0, system_time_counter;
  hmcs_mode_t host_mode;
  hmcs_if_en_t host_if_en;
  hmcs_ref_t ref_sel_state;
  logic host_interrupt_request_o, host_interrupt_request_oe, irq_pin;
  logic serial_bidir_data_o, serial_bidir_data_oe, sd_pin, prev, prev_f;
  logic [11:0] gpio_o, gpio_oe;
  logic pll_ref_clock, dsp_core_clock, master_bit_clock, master_frame_clock;
  int fails = 0, check_count = 0, cyc = 0, n = 0, nf = 0;

  always #5 core_clk = ~core_clk;

  hmcs_top u_hmcs_top (.*);
  hmcs_host_model u_hmcs_host_model (.irq_oe(host_interrupt_request_oe),
    .sd_o(serial_bidir_data_o), .sd_oe(serial_bidir_data_oe),
    .irq_pin(irq_pin), .sd_pin(sd_pin));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic boot(input logic [2:0] s);
    strap_pins = s;
    sys_rst = 1;
    step(10);
    sys_rst = 0;
    step(1);
  endtask
  function automatic logic [1:0] exp_mode(input logic [2:0] s);
    if (s[2] & s[1]) return {1'b0, ~s[0]};
    return s[1] ? 2'h2 : 2'h3;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report;
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      boot(3'(i));
      chk(33'(host_mode), 33'(exp_mode(3'(i))));
      chk(33'(host_if_en), 33'(4'h8 >> exp_mode(3'(i))));
      strap_pins = ~strap_pins;
      gpio_drive_req = 12'hFFF;
      sdata_drive_req = 1;
      step(2);
      chk(33'(host_mode), 33'(exp_mode(3'(i))));
      chk(33'(gpio_oe), exp_mode(3'(i)) > 1 ? 33'h0 : 33'hFFF);
      chk(33'(gpio_o), 33'hA5A);
      chk(33'(serial_bidir_data_oe), exp_mode(3'(i)) > 1 ? 33'h1 : 33'h0);
      gpio_drive_req = '0;
      sdata_drive_req = 0;
      $display("strap test %0d done", i);
    end
    boot(3'h2);
    sdata_drive_req = 1;
    sdata_out_val = 1;
    step(2);
    chk(33'(sd_pin), 33'h1);
    chk(33'(serial_bidir_data_oe), 33'h0);
    sdata_out_val = 0;
    irq_assert = 1;
    step(2);
    chk(33'(sd_pin), 33'h0);
    chk(33'(irq_pin), 33'h0);
    irq_assert = 0;
    step(2);
    chk(33'(irq_pin), 33'h1);
    $display("pin test done");
    pll_bypass_select = 1;
    external_clock_input = 1;
    step(1);
    chk(33'(dsp_core_clock), 33'h1);
    pll_bypass_select = 0;
    step(1);
    chk(33'(dsp_core_clock), 33'h0);
    for (int r = 2; r >= 0; r--) begin
      ref_sel = hmcs_ref_t'(r);
      ref_sel_we = 1;
      step(1);
      ref_sel = hmcs_ref_t'(2'h3);
      step(1);
      ref_sel_we = 0;
      {serial_bit_clock_two, serial_bit_clock_one, external_clock_input} =
        3'(1 << r);
      step(1);
      chk(33'(ref_sel_state), 33'(r));
      chk(33'(pll_ref_clock), 33'h1);
    end
    master_timing_en = 1;
    step(8);
    for (int k = 0; k < 16; k++) begin
      prev = master_bit_clock;
      prev_f = master_frame_clock;
      step(1);
      if (master_bit_clock !== prev) n++;
      if (master_frame_clock !== prev_f) nf++;
    end
    chk(33'(n), 33'h8);
    chk(33'(nf), 33'h2);
    stc_load_val = 33'h1_FFFF_FFFE;
    stc_load = 1;
    step(1);
    stc_load = 0;
    step(5);
    chk(system_time_counter, 33'h0_0000_0003);
    clk_en = 0;
    step(4);
    chk(system_time_counter, 33'h0_0000_0003);
    clk_en = 1;
    step(1);
    chk(system_time_counter, 33'h0_0000_0004);
    $display("clock test done");
    final_report;
  end
endmodule

`default_nettype wire
